// [pkg/cpu_mem_pkg.sv]
// shared constants and carrier types for the processor memory interface
package cpu_mem_pkg;

   // widths and answer buffer depth
   localparam int DATA_W        = 32;
   localparam int MODE_W        = 5;
   localparam int BURST_W       = 4;
   localparam int BUF_DEPTH     = 2;
   localparam int COUNT_W       = 2;

   // access size encodings
   localparam logic [1:0] SIZE_BYTE     = 2'h0;
   localparam logic [1:0] SIZE_HALF     = 2'h1;
   localparam logic [1:0] SIZE_WORD     = 2'h2;
   localparam logic [1:0] SIZE_RESERVED = 2'h3;

   // processor mode that means unprivileged execution
   localparam logic [4:0] MODE_USER     = 5'h10;

   // reset values of the pin-facing registers, and the empty and full buffer counts
   localparam logic [4:0] MODE_RESET    = 5'h13;
   localparam logic [3:0] BURST_NONE    = 4'h0;
   localparam logic [31:0] WORD_ZERO    = 32'h0000_0000;
   localparam logic [1:0] COUNT_ZERO    = 2'h0;
   localparam logic [1:0] COUNT_FULL    = 2'h2;

   // phase of the load/store side
   typedef enum logic [2:0] {
      LS_IDLE   = 3'b001,
      LS_ACCESS = 3'b010,
      LS_LOCKED = 3'b100
   } ls_phase_type;

   // instruction fetch command from the core pipeline
   typedef struct packed {
      logic        req;
      logic [31:1] addr;
      logic        seq;
      logic [4:0]  mode;
      logic        compact;
      logic        cancel;
   } fetch_cmd_type;

   // load/store command from the core pipeline
   typedef struct packed {
      logic        req;
      logic        spec;
      logic [31:0] addr;
      logic        write;
      logic [1:0]  size;
      logic        seq;
      logic        more;
      logic [4:0]  mode;
      logic        privileged;
      logic        lock;
      logic [3:0]  burst;
      logic [31:0] wdata;
      logic        cancel;
   } ls_cmd_type;

   // fetched word returned to the core
   typedef struct packed {
      logic        valid;
      logic [31:0] word;
      logic        fault;
      logic        breakpoint;
   } fetch_rsp_type;

   // completed load/store returned to the core
   typedef struct packed {
      logic [31:0] data;
      logic        fault;
      logic        write;
   } ls_rsp_type;

endpackage

// [testbench/cpu_dual_memory_interface_bench.sv]
// self-checking bench for the processor memory interface
`timescale 1ns/1ps

module cpu_dual_memory_interface_bench;
   import cpu_mem_pkg::*;
   logic          clk = 1'b0, rst = 1'b1, stall_enable = 1'b1, ls_rsp_ready = 1'b1;
   fetch_cmd_type fetch_cmd = '0;
   ls_cmd_type    ls_cmd = '0;
   logic          ls_cmd_ready, fetch_request_n, fetch_sequential, fetch_privilege, compact_isa_state;
   logic          fetch_cancel, fetch_fault, fetch_breakpoint, access_direction, load_store_request_n;
   logic          load_store_sequential, load_store_follow_on, load_store_privilege, load_store_locked;
   logic          speculative_hint_n, load_store_cancel, load_store_fault, watchpoint_halt, ls_rsp_valid, debug_halt;
   logic [31:1]   fetch_addr;
   logic [4:0]    fetch_cpu_mode, load_store_cpu_mode;
   logic [1:0]    access_size;
   logic [3:0]    burst_length;
   logic [31:0]   fetch_word_in, load_store_addr, load_store_wdata, load_store_rdata;
   fetch_rsp_type fetch_rsp;
   ls_rsp_type    ls_rsp;
   int            num_errors = 0, tests_run = 0;

   always #20 clk = ~clk;

   cpu_mem_if i_dut (.clk(clk), .rst(rst), .stall_enable(stall_enable), .fetch_cmd(fetch_cmd), .ls_cmd(ls_cmd),
      .ls_cmd_ready(ls_cmd_ready), .fetch_addr(fetch_addr), .fetch_request_n(fetch_request_n),
      .fetch_sequential(fetch_sequential), .fetch_cpu_mode(fetch_cpu_mode), .fetch_privilege(fetch_privilege),
      .compact_isa_state(compact_isa_state), .fetch_cancel(fetch_cancel), .fetch_word_in(fetch_word_in),
      .fetch_fault(fetch_fault), .fetch_breakpoint(fetch_breakpoint), .load_store_addr(load_store_addr),
      .access_direction(access_direction), .access_size(access_size), .load_store_request_n(load_store_request_n),
      .load_store_sequential(load_store_sequential), .load_store_follow_on(load_store_follow_on),
      .load_store_cpu_mode(load_store_cpu_mode), .load_store_privilege(load_store_privilege),
      .load_store_locked(load_store_locked), .speculative_hint_n(speculative_hint_n),
      .load_store_cancel(load_store_cancel), .burst_length(burst_length), .load_store_wdata(load_store_wdata),
      .load_store_rdata(load_store_rdata), .load_store_fault(load_store_fault), .watchpoint_halt(watchpoint_halt),
      .fetch_rsp(fetch_rsp), .ls_rsp_valid(ls_rsp_valid), .ls_rsp(ls_rsp), .ls_rsp_ready(ls_rsp_ready),
      .debug_halt(debug_halt));

   mem_model i_mem (.clk(clk), .rst(rst), .stall_enable(stall_enable), .fetch_addr(fetch_addr),
      .fetch_request_n(fetch_request_n), .load_store_addr(load_store_addr),
      .load_store_request_n(load_store_request_n), .access_direction(access_direction),
      .fetch_word_in(fetch_word_in), .fetch_fault(fetch_fault), .fetch_breakpoint(fetch_breakpoint),
      .load_store_rdata(load_store_rdata), .load_store_fault(load_store_fault), .watchpoint_halt(watchpoint_halt));

   // one comparison, counted; values are zero-extended to 32 bits
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         num_errors++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic close_out;
      if (num_errors == 0 && tests_run > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   task automatic timed_out(input string what);
      num_errors++;
      $display("wrong value %s expected answer seen none", what);
      close_out();
   endtask

   // fetch: pins from the taking edge, optional stall in the access cycle, optional cancel
   task automatic do_fetch(input logic [31:0] a, input logic [4:0] m, input logic cmp, sq, kill, input int stalls);
      int   i;
      logic seen;
      @(posedge clk) fetch_cmd <= '{1'b1, a[31:1], sq, m, cmp, 1'b0};
      @(posedge clk) fetch_cmd <= '{1'b0, a[31:1], 1'b0, m, cmp, kill};
      #1;
      chk("fetch_request_n", 0, fetch_request_n);
      chk("fetch_addr", a, {fetch_addr, 1'b0});
      chk("fetch_sequential", sq, fetch_sequential);
      chk("fetch_cpu_mode", m, fetch_cpu_mode);
      chk("fetch_privilege", m != MODE_USER, fetch_privilege);
      chk("compact_isa_state", cmp, compact_isa_state);
      @(posedge clk) fetch_cmd <= '0;
      stall_enable <= (stalls == 0);
      #1;
      chk("fetch_cancel", kill, fetch_cancel);
      chk("fetch_request_n", 1, fetch_request_n);
      for (i = 0; i < stalls; i++) begin
         @(posedge clk) if (i == stalls - 1) stall_enable <= 1'b1;
         #1;
         chk("fetch_rsp.valid", 0, fetch_rsp.valid);
      end
      seen = 1'b0;
      for (i = 0; i < 4 && !seen; i++) begin
         @(posedge clk);
         #1 seen = (fetch_rsp.valid === 1'b1);
      end
      if (kill)
         chk("fetch_rsp.valid", 0, seen);
      else begin
         if (!seen) timed_out("fetch_rsp");
         chk("fetch_rsp.word", a ^ 32'h5a5a_c3c3, fetch_rsp.word);
         chk("fetch_rsp.fault", a[31:28] == 4'hf, fetch_rsp.fault);
         chk("fetch_rsp.breakpoint", a[27:24] == 4'hb, fetch_rsp.breakpoint);
      end
   endtask

   // load/store: pins, watchpoint halt, then the buffered answer
   task automatic do_ls(input ls_cmd_type c);
      int         i;
      logic       seen;
      ls_cmd_type k;
      k = '0;
      k.cancel = c.cancel;
      @(posedge clk) ls_cmd <= c;
      @(posedge clk) ls_cmd <= k;
      #1;
      chk("load_store_request_n", 0, load_store_request_n);
      chk("load_store_addr", c.addr, load_store_addr);
      chk("access_direction", c.write, access_direction);
      chk("access_size", c.size == SIZE_RESERVED ? SIZE_WORD : c.size, access_size);
      chk("load_store_cpu_mode", c.mode, load_store_cpu_mode);
      chk("load_store_privilege", c.privileged, load_store_privilege);
      chk("load_store_locked", c.lock, load_store_locked);
      chk("load_store_follow_on", c.more, load_store_follow_on);
      chk("load_store_sequential", c.seq, load_store_sequential);
      chk("burst_length", c.burst, burst_length);
      chk("load_store_wdata", c.write ? c.wdata : WORD_ZERO, load_store_wdata);
      chk("speculative_hint_n", 1, speculative_hint_n);
      @(posedge clk);
      #1;
      chk("debug_halt", c.addr[27:24] == 4'hc, debug_halt);
      chk("load_store_request_n", 1, load_store_request_n);
      chk("load_store_cancel", c.cancel, load_store_cancel);
      seen = 1'b0;
      for (i = 0; i < 4 && !seen; i++) begin
         @(posedge clk);
         #1 seen = (ls_rsp_valid === 1'b1);
      end
      if (c.cancel)
         chk("ls_rsp_valid", 0, seen);
      else begin
         if (!seen) timed_out("ls_rsp_valid");
         chk("ls_rsp.data", c.write ? WORD_ZERO : c.addr ^ 32'h5a5a_c3c3, ls_rsp.data);
         chk("ls_rsp.fault", c.addr[31:28] == 4'hf, ls_rsp.fault);
         chk("ls_rsp.write", c.write, ls_rsp.write);
      end
   endtask

   // every size code, alternating direction and qualifiers
   task automatic ls_sizes;
      int i;
      for (i = 0; i < 4; i++)
         do_ls('{1'b1, 1'b0, 32'h0000_2000 + 32'(i * 4), i[0], i[1:0], i[1], i[0], MODE_RESET - 5'(i), i[1], i[0],
                 4'(i + 1), 32'hc0de_0000 + 32'(i), i[0] & i[1]});
   endtask

   // hint alone drives address with the strobe high
   task automatic spec_hint;
      ls_cmd_type c;
      c = '0;
      c.spec = 1'b1;
      c.addr = 32'h0000_4444;
      @(posedge clk) ls_cmd <= c;
      @(posedge clk) ls_cmd <= '0;
      #1;
      chk("speculative_hint_n", 0, speculative_hint_n);
      chk("load_store_request_n", 1, load_store_request_n);
      chk("load_store_addr", c.addr, load_store_addr);
   endtask

   // core stalls answers: two taken, the rest refused, then drained
   task automatic buffer_fill;
      ls_cmd_type c;
      int         i, n;
      c = '0;
      c.req = 1'b1;
      c.addr = 32'h0000_0100;
      c.size = SIZE_WORD;
      @(posedge clk) ls_cmd <= c;
      ls_rsp_ready <= 1'b0;
      n = 0;
      for (i = 0; i < 8; i++) begin
         @(posedge clk);
         #1 if (load_store_request_n === 1'b0) n++;
      end
      chk("requests taken", 2, n);
      chk("ls_cmd_ready", 0, ls_cmd_ready);
      @(posedge clk) ls_cmd <= '0;
      ls_rsp_ready <= 1'b1;
      #1 n = (ls_rsp_valid === 1'b1);
      for (i = 0; i < 4; i++) begin
         @(posedge clk);
         #1 if (ls_rsp_valid === 1'b1) n++;
      end
      chk("answers drained", 2, n);
      chk("ls_cmd_ready", 1, ls_cmd_ready);
   endtask

   initial begin
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      #1;
      chk("fetch_request_n", 1, fetch_request_n);
      chk("load_store_request_n", 1, load_store_request_n);
      chk("access_size", SIZE_WORD, access_size);
      do_fetch(32'h0000_1000, MODE_USER, 1'b1, 1'b0, 1'b0, 0);
      do_fetch(32'hfb00_2002, MODE_RESET, 1'b0, 1'b1, 1'b0, 3);
      do_fetch(32'h0000_3000, 5'h1f, 1'b0, 1'b0, 1'b1, 0);
      ls_sizes();
      do_ls('{1'b1, 1'b1, 32'hfc00_0040, 1'b0, SIZE_BYTE, 1'b0, 1'b0, MODE_USER, 1'b0, 1'b0, 4'h0, 32'h0, 1'b0});
      spec_hint();
      buffer_fill();
      close_out();
   end
endmodule // cpu_dual_memory_interface_bench

// [testbench/mem_model.sv]
// instruction and data memory model facing the interface pins
`timescale 1ns/1ps

module mem_model (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        stall_enable,
   input  wire logic [31:1] fetch_addr,
   input  wire logic        fetch_request_n,
   input  wire logic [31:0] load_store_addr,
   input  wire logic        load_store_request_n,
   input  wire logic        access_direction,
   output logic [31:0]      fetch_word_in,
   output logic             fetch_fault,
   output logic             fetch_breakpoint,
   output logic [31:0]      load_store_rdata,
   output logic             load_store_fault,
   output logic             watchpoint_halt
);
   import cpu_mem_pkg::*;
   logic        f_acc, l_acc, l_rd;
   logic [31:0] f_a, l_a;

   // access cycle follows a low strobe; a stalled edge holds everything
   always_ff @(posedge clk) begin
      if (rst) begin
         f_acc <= 1'b0;
         l_acc <= 1'b0;
         l_rd  <= 1'b0;
         f_a   <= '0;
         l_a   <= '0;
      end else if (stall_enable) begin
         f_acc <= !fetch_request_n;
         f_a   <= {fetch_addr, 1'b0};
         l_acc <= !load_store_request_n;
         l_rd  <= !load_store_request_n && !access_direction;
         l_a   <= load_store_addr;
      end
   end

   // outside an access the buses show the inverse, so stale data never matches
   assign fetch_word_in    = f_acc ? (f_a ^ 32'h5a5a_c3c3) : ~(f_a ^ 32'h5a5a_c3c3);
   assign fetch_fault      = f_acc && (f_a[31:28] == 4'hf);
   assign fetch_breakpoint = f_acc && (f_a[27:24] == 4'hb);
   assign load_store_rdata = l_rd ? (l_a ^ 32'h5a5a_c3c3) : ~(l_a ^ 32'h5a5a_c3c3);
   // hint is ignored, so no speculative transfer ever needs an abort here
   assign load_store_fault = l_acc && (l_a[31:28] == 4'hf);
   // single master: a locked access needs no arbitration here
   assign watchpoint_halt  = !load_store_request_n && (load_store_addr[27:24] == 4'hc);
endmodule // mem_model

// [verilog/cpu_mem_if.sv]
// processor-side fetch and load/store memory interface
//
// Overview of operation
// - fetch strobe low means fetch next cycle
// - fetch sequential flag follows previous fetch
// - fetch mode outputs show processor mode
// - fetch privilege low only in user mode
// - compact state high in 16-bit instruction set
// - cancel withdraws previous cycle's request
// - fetch fault marks fetched word aborted
// - breakpoint tags fetched word for debug
// - 31-bit fetch address, 32-bit load/store address
// - load/store fault marks access aborted
// - store words driven in the request cycle of writes
// - watchpoint at request cycle enters debug
// - lock keeps other masters off memory
// - size 10 word, 01 half, 00 byte
// - follow-on flag announces next sequential access
// - load/store strobe low means access next cycle
// - load/store mode outputs show access mode
// - direction low read, high write
// - speculative hint never with load/store strobe
// - load/store privilege low for user access
// - load/store sequential flag follows previous access
// - stall enable low freezes the memory-side pins, not the core-side answers and halt
`timescale 1ns/1ps

module cpu_mem_if (
   input  wire logic                       clk,
   input  wire logic                       rst,
   input  wire logic                       stall_enable,
   input  wire cpu_mem_pkg::fetch_cmd_type fetch_cmd,
   input  wire cpu_mem_pkg::ls_cmd_type    ls_cmd,
   output logic                            ls_cmd_ready,
   output logic [31:1]                     fetch_addr,
   output logic                            fetch_request_n,
   output logic                            fetch_sequential,
   output logic [4:0]                      fetch_cpu_mode,
   output logic                            fetch_privilege,
   output logic                            compact_isa_state,
   output logic                            fetch_cancel,
   input  wire logic [31:0]                fetch_word_in,
   input  wire logic                       fetch_fault,
   input  wire logic                       fetch_breakpoint,
   output logic [31:0]                     load_store_addr,
   output logic                            access_direction,
   output logic [1:0]                      access_size,
   output logic                            load_store_request_n,
   output logic                            load_store_sequential,
   output logic                            load_store_follow_on,
   output logic [4:0]                      load_store_cpu_mode,
   output logic                            load_store_privilege,
   output logic                            load_store_locked,
   output logic                            speculative_hint_n,
   output logic                            load_store_cancel,
   output logic [3:0]                      burst_length,
   output logic [31:0]                     load_store_wdata,
   input  wire logic [31:0]                load_store_rdata,
   input  wire logic                       load_store_fault,
   input  wire logic                       watchpoint_halt,
   output cpu_mem_pkg::fetch_rsp_type      fetch_rsp,
   output logic                            ls_rsp_valid,
   output cpu_mem_pkg::ls_rsp_type         ls_rsp,
   input  wire logic                       ls_rsp_ready,
   output logic                            debug_halt
);
   import cpu_mem_pkg::*;

   // whole state of the interface, apart from the answer buffer, in one register
   typedef struct packed {
      logic [31:1]   f_addr;
      logic          f_req_n;
      logic          f_seq;
      logic [4:0]    f_mode;
      logic          f_priv;
      logic          f_compact;
      logic          f_cancel;
      logic          f_access;
      fetch_rsp_type f_rsp;
      logic [31:0]   d_addr;
      logic          d_dir;
      logic [1:0]    d_size;
      logic          d_req_n;
      logic          d_seq;
      logic          d_more;
      logic [4:0]    d_mode;
      logic          d_priv;
      logic          d_lock;
      logic          d_spec_n;
      logic          d_cancel;
      logic [3:0]    d_burst;
      logic [31:0]   d_wdata;
      logic          d_access;
      logic          d_acc_dir;
      ls_phase_type  phase;
      logic          cmd_ready;
      logic          dbg_halt;
   } core_state_type;

   core_state_type s_reg;
   core_state_type s_next;

   logic          fetch_take;
   logic          ls_take;
   logic          ls_done;
   ls_rsp_type    ls_done_data;
   logic          buf_in_ready;
   logic [1:0]    buf_count;
   logic          buf_pop;
   logic [2:0]    count_after;

   // a command is only taken on an advancing edge
   assign fetch_take = stall_enable && fetch_cmd.req;
   assign ls_take    = stall_enable && ls_cmd.req && s_reg.cmd_ready;

   // a completed, uncancelled load/store enters the answer buffer
   assign ls_done = stall_enable && s_reg.d_access && !s_reg.d_cancel;
   // direction of the access cycle itself; the pin may already show the next request
   assign ls_done_data.data  = s_reg.d_acc_dir ? WORD_ZERO : load_store_rdata;
   assign ls_done_data.fault = load_store_fault;
   assign ls_done_data.write = s_reg.d_acc_dir;
   assign buf_pop = ls_rsp_valid && ls_rsp_ready;

   // buffer occupancy after this edge, used to reserve room for accesses in flight
   assign count_after = 3'({1'b0, buf_count} + {2'b00, ls_done} - {2'b00, buf_pop});

   ls_rsp_buffer u_rsp_buf (
      .clk       (clk),
      .rst       (rst),
      .in_valid  (ls_done),
      .in_data   (ls_done_data),
      .in_ready  (buf_in_ready),
      .out_valid (ls_rsp_valid),
      .out_data  (ls_rsp),
      .out_ready (ls_rsp_ready),
      .count     (buf_count)
   );

   // next state: every pin value is set for the cycle after the edge
   always_comb begin
      s_next = s_reg;
      s_next.f_rsp.valid = 1'b0;
      s_next.dbg_halt    = 1'b0;
      if (stall_enable) begin
         // instruction side
         s_next.f_req_n  = !fetch_cmd.req;
         s_next.f_seq    = fetch_cmd.req && fetch_cmd.seq;
         s_next.f_cancel = fetch_cmd.cancel && !s_reg.f_req_n;
         s_next.f_access = !s_reg.f_req_n;
         s_next.f_mode   = fetch_cmd.mode;
         s_next.f_priv   = (fetch_cmd.mode != MODE_USER);
         s_next.f_compact = fetch_cmd.compact;
         if (fetch_take) begin
            s_next.f_addr = fetch_cmd.addr;
         end
         // word of the access cycle just ending, unless it was withdrawn
         if (s_reg.f_access && !s_reg.f_cancel) begin
            s_next.f_rsp.valid      = 1'b1;
            s_next.f_rsp.word       = fetch_word_in;
            s_next.f_rsp.fault      = fetch_fault;
            s_next.f_rsp.breakpoint = fetch_breakpoint;
         end
         // load/store side
         s_next.d_req_n  = !ls_take;
         s_next.d_cancel = ls_cmd.cancel && !s_reg.d_req_n;
         s_next.d_access = !s_reg.d_req_n;
         s_next.d_acc_dir = s_reg.d_dir;
         s_next.d_seq    = ls_take && ls_cmd.seq;
         s_next.d_more   = ls_take && ls_cmd.more;
         s_next.d_lock   = ls_take && ls_cmd.lock;
         s_next.d_burst  = ls_take ? ls_cmd.burst : BURST_NONE;
         // a hint is only offered in a cycle with no request
         s_next.d_spec_n = !(ls_cmd.spec && !ls_take);
         if (ls_take || ls_cmd.spec) begin
            s_next.d_addr = ls_cmd.addr;
            s_next.d_mode = ls_cmd.mode;
            s_next.d_priv = ls_cmd.privileged;
         end
         if (ls_take) begin
            s_next.d_dir  = ls_cmd.write;
            // the reserved pattern is never put out; it is widened to a word
            s_next.d_size = (ls_cmd.size == SIZE_RESERVED) ? SIZE_WORD : ls_cmd.size;
         end
         // store data only travels while the access is a write
         s_next.d_wdata = (ls_take && ls_cmd.write) ? ls_cmd.wdata : WORD_ZERO;
         s_next.dbg_halt = !s_reg.d_req_n && watchpoint_halt;
      end
      // room is kept for each access still able to reach the buffer: requested and in access
      s_next.cmd_ready = (3'(count_after + {2'b00, s_next.d_access} + {2'b00, !s_next.d_req_n}) < 3'(COUNT_FULL));
      if (s_next.d_lock) begin
         s_next.phase = LS_LOCKED;
      end else if (!s_next.d_req_n || s_next.d_access) begin
         s_next.phase = LS_ACCESS;
      end else begin
         s_next.phase = LS_IDLE;
      end
   end

   // single state register; stall low leaves the memory-side pins untouched
   always_ff @(posedge clk) begin
      if (rst) begin
         s_reg           <= '0;
         s_reg.f_req_n   <= 1'b1;
         s_reg.f_mode    <= MODE_RESET;
         s_reg.f_priv    <= 1'b1;
         s_reg.d_req_n   <= 1'b1;
         s_reg.d_mode    <= MODE_RESET;
         s_reg.d_priv    <= 1'b1;
         s_reg.d_spec_n  <= 1'b1;
         s_reg.d_size    <= SIZE_WORD;
         s_reg.phase     <= LS_IDLE;
         s_reg.cmd_ready <= 1'b1;
      end else begin
         s_reg <= s_next;
      end
   end

   // pins straight from the state register
   assign fetch_addr            = s_reg.f_addr;
   assign fetch_request_n       = s_reg.f_req_n;
   assign fetch_sequential      = s_reg.f_seq;
   assign fetch_cpu_mode        = s_reg.f_mode;
   assign fetch_privilege       = s_reg.f_priv;
   assign compact_isa_state     = s_reg.f_compact;
   assign fetch_cancel          = s_reg.f_cancel;
   assign fetch_rsp             = s_reg.f_rsp;
   assign load_store_addr       = s_reg.d_addr;
   assign access_direction      = s_reg.d_dir;
   assign access_size           = s_reg.d_size;
   assign load_store_request_n  = s_reg.d_req_n;
   assign load_store_sequential = s_reg.d_seq;
   assign load_store_follow_on  = s_reg.d_more;
   assign load_store_cpu_mode   = s_reg.d_mode;
   assign load_store_privilege  = s_reg.d_priv;
   assign load_store_locked     = s_reg.d_lock;
   assign speculative_hint_n    = s_reg.d_spec_n;
   assign load_store_cancel     = s_reg.d_cancel;
   assign burst_length          = s_reg.d_burst;
   assign load_store_wdata      = s_reg.d_wdata;
   assign ls_cmd_ready          = s_reg.cmd_ready;
   assign debug_halt            = s_reg.dbg_halt;

   // the fetch strobe reflects the request seen at the last advancing edge
   a_fetch_strobe: assert property (@(posedge clk) disable iff (rst)
      $past(stall_enable) && !$past(rst) |-> fetch_request_n == !$past(fetch_cmd.req))
      else $error("fetch strobe does not match previous request");

   // privilege output agrees with the mode presented beside it
   a_fetch_priv_mode: assert property (@(posedge clk) disable iff (rst)
      fetch_privilege == (fetch_cpu_mode != MODE_USER))
      else $error("fetch privilege disagrees with mode");

   // a cancel only ever follows a cycle with a fetch request
   a_cancel_follows: assert property (@(posedge clk) disable iff (rst)
      fetch_cancel && $past(stall_enable) |-> $past(!fetch_request_n))
      else $error("fetch cancel without preceding request");

   // a fetched word carries the fault sampled at the end of its access
   a_fetch_fault_kept: assert property (@(posedge clk) disable iff (rst)
      fetch_rsp.valid |-> fetch_rsp.fault == $past(fetch_fault) && fetch_rsp.word == $past(fetch_word_in))
      else $error("fetched word lost its fault flag");

   // watchpoint at the end of a request cycle raises the halt next cycle
   a_watch_halt: assert property (@(posedge clk) disable iff (rst)
      stall_enable && !load_store_request_n && watchpoint_halt ##1 !$past(rst) |-> debug_halt)
      else $error("watchpoint did not halt");

   // the reserved size pattern never reaches the pins
   a_size_legal: assert property (@(posedge clk) disable iff (rst)
      access_size != SIZE_RESERVED)
      else $error("reserved access size driven");

   // hint and load/store strobe are never low together
   a_spec_excl: assert property (@(posedge clk) disable iff (rst)
      !speculative_hint_n |-> load_store_request_n)
      else $error("speculative hint with request");

   // a taken write puts its data on the store bus for the access
   a_store_data: assert property (@(posedge clk) disable iff (rst)
      ls_take && ls_cmd.write ##1 !$past(rst) |-> access_direction && load_store_wdata == $past(ls_cmd.wdata))
      else $error("store word not driven for write");

   // a locked command shows lock and the locked phase on the next cycle
   a_lock_shown: assert property (@(posedge clk) disable iff (rst)
      ls_take && ls_cmd.lock |=> load_store_locked && s_reg.phase == LS_LOCKED)
      else $error("lock not presented");

   // with stall low the fetch address, load/store strobe and load/store address do not move
   a_stall_freeze: assert property (@(posedge clk) disable iff (rst)
      !stall_enable ##1 !$past(rst) |-> $stable(fetch_addr) && $stable(load_store_request_n) && $stable(load_store_addr))
      else $error("pins changed during stall");

   // room reserved ahead means the buffer never refuses an answer
   a_buffer_room: assert property (@(posedge clk) disable iff (rst)
      ls_done |-> buf_in_ready)
      else $error("answer buffer overflow");

endmodule // cpu_mem_if

// [verilog/ls_rsp_buffer.sv]
// two-entry buffer for completed load/store answers
`timescale 1ns/1ps

module ls_rsp_buffer (
   input  wire logic                   clk,
   input  wire logic                   rst,
   input  wire logic                   in_valid,
   input  wire cpu_mem_pkg::ls_rsp_type in_data,
   output logic                        in_ready,
   output logic                        out_valid,
   output cpu_mem_pkg::ls_rsp_type     out_data,
   input  wire logic                   out_ready,
   output logic [1:0]                  count
);
   import cpu_mem_pkg::*;

   typedef struct packed {
      ls_rsp_type  head;
      ls_rsp_type  tail;
      logic [1:0]  count;
   } buf_state_type;

   buf_state_type s_reg;
   buf_state_type s_next;
   logic          push;
   logic          pop;

   assign in_ready  = (s_reg.count != COUNT_FULL);
   assign out_valid = (s_reg.count != COUNT_ZERO);
   assign out_data  = s_reg.head;
   assign count     = s_reg.count;
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   // head always holds the oldest word so the reader sees a register
   always_comb begin
      s_next = s_reg;
      if (pop) begin
         s_next.head = s_reg.tail;
      end
      if (push) begin
         if (s_reg.count == COUNT_ZERO || (s_reg.count == 2'h1 && pop)) begin
            s_next.head = in_data;
         end else begin
            s_next.tail = in_data;
         end
      end
      s_next.count = 2'(s_reg.count + {1'b0, push} - {1'b0, pop});
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   a_buf_no_over: assert property (@(posedge clk) disable iff (rst) s_reg.count <= COUNT_FULL)
      else $error("answer buffer count beyond depth");

endmodule // ls_rsp_buffer
